/* File: dv/ofs_checker.sv */
`include "ofs_map.svh"

module ofs_checker
    import ofs_pkg::*;
(
    input wire logic                      ref_clk,         // Clock
    input wire logic                      srst,            // Sync reset
    input wire logic                      avs_read,        // Read
    input wire logic                      avs_write,       // Write
    input wire logic [31:0]               avs_readdata,    // Read data
    input wire logic                      avs_waitrequest, // Stall
    input wire ofs_ctl_type               ctl,             // Sequencer status
    input wire logic [`OFS_NUM_DIN-1:0]   din_pin,         // Switch inputs
    input wire logic [`OFS_NUM_ADIG-1:0]  adig_pin,        // Sender lines
    input wire logic [`OFS_NUM_RELAY-1:0] relay_out,       // Relays
    input wire logic [`OFS_NUM_RELAY-1:0] dig_out,         // Digital outputs
    input wire logic                      can_tx_en        // CAN permit
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // Properties
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    wire req = avs_read || avs_write;

    sequence s_ask;
        req && avs_waitrequest;
    endsequence

    // Six quiet cycles outlast every path
    sequence s_quiet;
        ($stable(ctl) && $stable(din_pin) && $stable(adig_pin) && !avs_write) [*6];
    endsequence

    a_answer_next: assert property (s_ask |=> !avs_waitrequest)
        else $error("no answer next cycle");
    a_stall_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("stall low too long");
    a_no_unasked: assert property ($fell(avs_waitrequest) |-> $past(req))
        else $error("unasked answer");
    a_idle_stall: assert property (!req |=> avs_waitrequest)
        else $error("waitrequest low while idle");
    a_data_holds: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data moved");
    a_reset_clear: assert property ($fell(srst) |-> (relay_out == 6'h0) && (dig_out == 6'h0)
        && !can_tx_en && avs_waitrequest)
        else $error("outputs not reset");
    a_can_gate: assert property (1'b1 |=> can_tx_en == ($past(ctl.state) != ENG_STANDBY))
        else $error("CAN permit wrong");
    a_outs_settle: assert property (s_quiet |=> $stable(relay_out) && $stable(dig_out))
        else $error("outputs moved");
endmodule

bind ofs_top ofs_checker ofs_checker_inst (
    .ref_clk(ref_clk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctl(ctl),
    .din_pin(din_pin), .adig_pin(adig_pin), .relay_out(relay_out), .dig_out(dig_out),
    .can_tx_en(can_tx_en)
);

/* File: dv/ofs_load_model.sv */
module ofs_load_model (
    input  wire logic        ref_clk,   // Clock
    input  wire logic [5:0]  closed_sw, // Switches closed to battery positive
    input  wire logic [7:0]  grounded,  // Senders shorted to battery negative
    input  wire logic [5:0]  relay_out, // Relay coils
    input  wire logic [5:0]  dig_out,   // Lamp and valve drivers
    output logic      [5:0]  din_pin,   // Switch lines
    output logic      [7:0]  adig_pin,  // Sender lines
    output logic      [11:0] energized  // Loads seen on
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // Field wiring
    // ********************************
    assign din_pin  = closed_sw;
    // Open sender pulled high
    assign adig_pin = ~grounded;

    always_ff @(posedge ref_clk) begin
        energized <= {dig_out, relay_out};
    end
endmodule

/* File: dv/ofs_tb_top.sv */
`include "ofs_map.svh"

module ofs_tb_top
    import ofs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic obs; logic [31:0] val;} ofs_note_type;

    logic         ref_clk = 1'b0;
    logic         srst = 1'b1;
    logic [7:0]   avs_address = 8'h00;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0000_0000;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic         can_tx_en;
    logic         probe = 1'b0;
    ofs_ctl_type  ctl = '0;
    logic [5:0]   closed_sw = 6'h00, relay_out, dig_out, din_pin;
    logic [7:0]   grounded = 8'h00, adig_pin;
    logic [11:0]  energized;
    int           bad_count = 0, checks = 0;
    ofs_note_type notes[$], nt;
    ofs_fn_type   fn_r[12] = '{default: FN_NOT_USED};
    logic [2:0]   idx_r[12] = '{default: 3'h0};
    logic         remind_r = 1'b0, clutch_m = 1'b0, run_m = 1'b0;
    logic [7:0]   rst_a[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h40, 8'h6C, 8'h20, 8'h41};
    ofs_eng_type  cl_st[5] = '{ENG_WARMUP, ENG_RUN, ENG_RUN, ENG_COOLDOWN, ENG_COOLDOWN};
    logic [15:0]  cl_rpm[5] = '{16'h07D0, 16'h05DB, 16'h05DC, 16'h0321, 16'h0320};
    logic         cl_exp[5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};

    always #12.5 ref_clk = ~ref_clk;

    ofs_top ofs_top_inst (
        .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctl(ctl),
        .din_pin(din_pin), .adig_pin(adig_pin), .relay_out(relay_out), .dig_out(dig_out),
        .can_tx_en(can_tx_en)
    );

    ofs_load_model ofs_load_model_inst (
        .ref_clk(ref_clk), .closed_sw(closed_sw), .grounded(grounded), .relay_out(relay_out),
        .dig_out(dig_out), .din_pin(din_pin), .adig_pin(adig_pin), .energized(energized)
    );

    // ********************************
    // Checking
    // ********************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    always @(posedge ref_clk) begin
        if (probe || (avs_read && avs_waitrequest === 1'b0)) begin
            nt = notes.pop_front();
            if (nt.obs) begin
                check("outputs", {19'h0, can_tx_en, energized}, nt.val);
            end else begin
                check("readdata", avs_readdata, nt.val);
            end
        end
    end

    function automatic logic fexp(input ofs_fn_type f, input logic [2:0] ix);
        logic cr, al;
        cr = ctl.state inside {ENG_CRANK, ENG_WARMUP, ENG_RUN, ENG_COOLDOWN};
        al = ctl.shutdown | ctl.warning | (|grounded);
        case (f)
            FN_FUEL, FN_EXCITE, FN_PIVOT: return cr;
            FN_ECU_EN: return ctl.state != ENG_STANDBY;
            FN_GOV: return ctl.state == ENG_RUN;
            FN_SHUTDOWN: return ctl.shutdown;
            FN_COMMON_ALARM, FN_REMOTE_ALARM: return al;
            FN_EXT_ALARM: return al & ~remind_r;
            FN_DAMPER_NDE: return ctl.keyed_on & ~ctl.ets_active;
            FN_DAMPER_NE: return ctl.ets_active;
            FN_NOT_AUTO: return ctl.manual;
            FN_THR_INC: return ctl.thr_inc;
            FN_THR_DEC: return ctl.thr_dec;
            FN_DIG_IN: return closed_sw[ix];
            FN_ANA_DIG: return grounded[ix];
            FN_FAIL_START: return ctl.overcrank & ctl.attempts_done;
            FN_IGN_OFF_SB: return ctl.keyed_on & (ctl.state != ENG_STANDBY);
            FN_IGN_ON_SB: return ctl.keyed_on;
            FN_CLUTCH: return clutch_m;
            FN_ENG_RUNNING: return run_m;
            default: return 1'b0;
        endcase
    endfunction

    // ********************************
    // Drivers
    // ********************************
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back('{1'b0, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic set_sel(input int i, input ofs_fn_type f, input logic [2:0] ix);
        fn_r[i] = f;
        idx_r[i] = ix;
        bus(1'b1, 8'(`OFS_REG_SEL_BASE + 4 * i), {21'h0, ix, 3'h0, f});
    endtask

    task automatic out_chk();
        logic [31:0] e;
        repeat (8) @(posedge ref_clk);
        e = 32'h0000_0000;
        for (int i = 0; i < 12; i++) e[i] = fexp(fn_r[i], idx_r[i]);
        e[12] = ctl.state != ENG_STANDBY;
        notes.push_back('{1'b1, e});
        probe <= 1'b1;
        @(posedge ref_clk);
        probe <= 1'b0;
    endtask

    task automatic set_ctl(input ofs_eng_type st, input logic [15:0] rpm, input logic go, halt);
        ofs_ctl_type c;
        c = ctl;
        c.state = st;
        c.rpm = rpm;
        c.start_det = go;
        c.stop_det = halt;
        ctl <= c;
        @(posedge ref_clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        bad_count++;
        give_verdict();
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        int k;
        logic [63:0] w;
        void'($urandom(32'h5597));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        foreach (rst_a[i]) rd(rst_a[i], 32'h0000_0000);
        bus(1'b1, `OFS_REG_SPEED, 32'h0320_05DC);
        rd(`OFS_REG_SPEED, 32'h0320_05DC);
        bus(1'b1, `OFS_REG_STATUS, 32'hFFFF_FFFF);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(`OFS_REG_STATUS, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        bus(1'b1, `OFS_REG_INPUTS, 32'hFFFF_FFFF);
        rd(`OFS_REG_INPUTS, 32'h00FF_0000);
        set_sel(11, FN_EXT_ALARM, 3'h5);
        rd(`OFS_REG_SEL_LAST, 32'h0000_0511);
        $display("test registers done");
        for (int r = 0; r < 24; r++) begin
            for (int i = 0; i < 12; i++) begin
                k = (r * 12 + i) % 22;
                if (k == 4 || k == 12) k = 0;
                set_sel(i, ofs_fn_type'(k), 3'((k == 16) ? $urandom % 8 : $urandom % 6));
            end
            remind_r = 1'($urandom);
            bus(1'b1, `OFS_REG_CTRL, {31'h0, remind_r});
            w = {$urandom, $urandom};
            ctl <= w[$bits(ofs_ctl_type)-1:0];
            @(posedge ref_clk);
            set_ctl(ofs_eng_type'(3'($urandom % 6)), ctl.rpm, 1'b0, 1'b1);
            closed_sw <= 6'($urandom);
            grounded  <= 8'($urandom);
            out_chk();
        end
        $display("test function table done");
        set_sel(0, FN_CLUTCH, 3'h0);
        set_sel(1, FN_ENG_RUNNING, 3'h0);
        foreach (cl_st[i]) begin
            set_ctl(cl_st[i], cl_rpm[i], 1'b0, 1'b0);
            clutch_m = cl_exp[i];
            out_chk();
        end
        // Start wins over stop
        set_ctl(ENG_RUN, 16'h0100, 1'b1, 1'b1);
        set_ctl(ENG_RUN, 16'h0100, 1'b0, 1'b0);
        run_m = 1'b1;
        out_chk();
        set_ctl(ENG_RUN, 16'h0100, 1'b0, 1'b1);
        set_ctl(ENG_RUN, 16'h0100, 1'b0, 1'b0);
        run_m = 1'b0;
        out_chk();
        $display("test clutch and running done");
        repeat (4) @(posedge ref_clk);
        give_verdict();
    end
endmodule

/* File: hw/ofs_map.svh */
`ifndef OFS_MAP_SVH
`define OFS_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define OFS_ADDR_W          8
`define OFS_REG_CTRL        8'h00
`define OFS_REG_SPEED       8'h04
`define OFS_REG_STATUS      8'h08
`define OFS_REG_INPUTS      8'h0C
`define OFS_REG_SEL_BASE    8'h40
`define OFS_REG_SEL_LAST    8'h6C

// ****************************************************************
// Field positions
// ****************************************************************
`define OFS_CTRL_REMIND_BIT 0
`define OFS_SPD_ENG_LSB     0
`define OFS_SPD_DIS_LSB     16
`define OFS_SEL_FN_LSB      0
`define OFS_SEL_IDX_LSB     8
`define OFS_ST_OUT_LSB      0
`define OFS_ST_CLUTCH_BIT   16
`define OFS_ST_GOV_BIT      17
`define OFS_ST_RUN_BIT      18
`define OFS_ST_CAN_BIT      19
`define OFS_IN_ADIG_LSB     8
`define OFS_IN_AEN_LSB      16

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define OFS_NUM_RELAY       6
`define OFS_NUM_OUT         12
`define OFS_NUM_DIN         6
`define OFS_NUM_ADIG        8
`define OFS_SPD_RESET       16'h0000
`define OFS_SEL_RESET       32'h0000_0000

`endif

/* File: hw/ofs_pkg.sv */
`include "ofs_map.svh"

package ofs_pkg;

    // Engine sequencer state as seen by the output logic
    typedef enum logic [2:0] {
        ENG_STANDBY,
        ENG_IDLE,
        ENG_CRANK,
        ENG_WARMUP,
        ENG_RUN,
        ENG_COOLDOWN
    } ofs_eng_type;

    // Selectable output functions
    typedef enum logic [4:0] {
        FN_NOT_USED,
        FN_FUEL,
        FN_ECU_EN,
        FN_EXCITE,
        FN_CLUTCH,
        FN_GOV,
        FN_SHUTDOWN,
        FN_COMMON_ALARM,
        FN_REMOTE_ALARM,
        FN_DAMPER_NDE,
        FN_NOT_AUTO,
        FN_DAMPER_NE,
        FN_ENG_RUNNING,
        FN_THR_INC,
        FN_THR_DEC,
        FN_DIG_IN,
        FN_ANA_DIG,
        FN_EXT_ALARM,
        FN_PIVOT,
        FN_FAIL_START,
        FN_IGN_OFF_SB,
        FN_IGN_ON_SB
    } ofs_fn_type;

    // Controller status arriving from the sequencer, same clock
    typedef struct packed {
        ofs_eng_type state;
        logic        keyed_on;
        logic        manual;
        logic        shutdown;
        logic        warning;
        logic        overcrank;
        logic        attempts_done;
        logic        start_det;
        logic        stop_det;
        logic        ets_active;
        logic        thr_inc;
        logic        thr_dec;
        logic [15:0] rpm;
    } ofs_ctl_type;

    // Per-output selection word
    typedef struct packed {
        logic [2:0] idx;
        ofs_fn_type fn;
    } ofs_sel_type;

endpackage

/* File: hw/ofs_top.sv */
`include "ofs_map.svh"

// Summary of operation
// R1 - Fuel on in crank/run state only
// R2 - ECU enable on unless in standby
// R3 - Alternator excite on in crank/run state
// R4 - Clutch engages after warm-up at engage speed
// R5 - Clutch drops in cool-down at disengage speed
// R6 - Governor on after warm-up, off at cool-down
// R7 - Shutdown output follows fault shutdown
// R8 - Common/remote alarm on any shutdown/warning
// R9 - External alarm, silenced by fault reminder
// R10 - De-energized damper off during stop delay
// R11 - Energized damper on during stop delay
// R12 - Not-auto output on in manual mode
// R13 - Running output from start to stop detect
// R14 - Any digital input may drive outputs
// R15 - Analog-as-digital active only at B- level
// R16 - Pivot power on in crank/run state
// R17 - Failed-to-start on exhausted attempts plus overcrank
// R18 - Ignition variant off during standby
// R19 - Ignition variant stays on in standby
// R20 - Raise/lower outputs carry throttle pulses
// R21 - Same function set for all twelve outputs
// R22 - No CAN transmit while ECU enable off
// R23 - Unused output held permanently off
module ofs_top
    import ofs_pkg::*;
(
    input  wire logic                          ref_clk,        // System clock, 40 MHz
    input  wire logic                          srst,           // Sync reset, active high
    input  wire logic [`OFS_ADDR_W-1:0]        avs_address,    // Byte address
    input  wire logic                          avs_read,       // Read request
    input  wire logic                          avs_write,      // Write request
    input  wire logic [31:0]                   avs_writedata,  // Write data
    input  wire logic [3:0]                    avs_byteenable, // Byte lanes
    output logic      [31:0]                   avs_readdata,   // Read data
    output logic                               avs_waitrequest,// Stall
    input  wire ofs_ctl_type                   ctl,            // Sequencer status
    input  wire logic [`OFS_NUM_DIN-1:0]       din_pin,        // Digital input pins, active high
    input  wire logic [`OFS_NUM_ADIG-1:0]      adig_pin,       // Analog-digital pins, high = open
    output logic      [`OFS_NUM_RELAY-1:0]     relay_out,      // Relay drivers
    output logic      [`OFS_NUM_RELAY-1:0]     dig_out,        // Digital output drivers
    output logic                               can_tx_en       // CAN transmit permit
);

    localparam int NO = `OFS_NUM_OUT;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [`OFS_NUM_DIN-1:0]  din_s1_r;
    logic [`OFS_NUM_DIN-1:0]  din_s2_r;
    logic [`OFS_NUM_ADIG-1:0] adig_s1_r;
    logic [`OFS_NUM_ADIG-1:0] adig_s2_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            din_s1_r  <= '0;
            din_s2_r  <= '0;
            adig_s1_r <= '1;
            adig_s2_r <= '1;
        end else begin
            din_s1_r  <= din_pin;
            din_s2_r  <= din_s1_r;
            adig_s1_r <= adig_pin;
            adig_s2_r <= adig_s1_r;
        end
    end

    // Only a pull to battery negative counts as active
    wire logic [`OFS_NUM_ADIG-1:0] adig_act = ~adig_s2_r; // [R15]

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic                        remind_en_r;
    logic [15:0]                 engage_rpm_r;
    logic [15:0]                 disengage_rpm_r;
    logic [`OFS_NUM_ADIG-1:0]    adig_alarm_en_r;
    ofs_sel_type                 sel_r [NO];
    logic                        wait_r;
    logic [31:0]                 rdata_r;

    wire logic req      = avs_read | avs_write;
    wire logic accept   = req & ~wait_r;
    wire logic wr_acc   = accept & avs_write;
    wire logic in_sel   = (avs_address >= `OFS_REG_SEL_BASE) &&
                          (avs_address <= `OFS_REG_SEL_LAST) &&
                          (avs_address[1:0] == 2'b00);
    wire logic [7:0] sel_off = avs_address - `OFS_REG_SEL_BASE;
    wire logic [3:0] sel_idx = sel_off[5:2];
    wire logic hit_ctrl   = avs_address == `OFS_REG_CTRL;
    wire logic hit_speed  = avs_address == `OFS_REG_SPEED;
    wire logic hit_status = avs_address == `OFS_REG_STATUS;
    wire logic hit_inputs = avs_address == `OFS_REG_INPUTS;

    // Byte-lane merge of write data into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    wire logic [31:0] ctrl_word  = {31'h0000_0000, remind_en_r};
    wire logic [31:0] speed_word = {disengage_rpm_r, engage_rpm_r};
    wire logic [31:0] ctrl_nxt   = merge(ctrl_word, avs_writedata, avs_byteenable);
    wire logic [31:0] speed_nxt  = merge(speed_word, avs_writedata, avs_byteenable);
    wire logic [31:0] inputs_wr  = merge({8'h00, adig_alarm_en_r, 16'h0000},
                                         avs_writedata, avs_byteenable);

    // Answer one edge after the request is seen; waitrequest drops for that edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~(req & wait_r);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            remind_en_r     <= 1'b0;
            engage_rpm_r    <= `OFS_SPD_RESET;
            disengage_rpm_r <= `OFS_SPD_RESET;
            adig_alarm_en_r <= '0;
        end else if (wr_acc) begin
            if (hit_ctrl) begin
                remind_en_r <= ctrl_nxt[`OFS_CTRL_REMIND_BIT];
            end
            if (hit_speed) begin
                engage_rpm_r    <= speed_nxt[`OFS_SPD_ENG_LSB +: 16];
                disengage_rpm_r <= speed_nxt[`OFS_SPD_DIS_LSB +: 16];
            end
            if (hit_inputs) begin
                adig_alarm_en_r <= inputs_wr[`OFS_IN_AEN_LSB +: `OFS_NUM_ADIG];
            end
        end
    end

    // Selection words, one per output, same layout for relays and digitals
    genvar gs;
    generate
        for (gs = 0; gs < NO; gs++) begin : g_sel
            wire logic [31:0] old_w = {21'h00_0000, sel_r[gs].idx, 3'h0, sel_r[gs].fn};
            wire logic [31:0] new_w = merge(old_w, avs_writedata, avs_byteenable);
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    sel_r[gs] <= ofs_sel_type'(`OFS_SEL_RESET);
                end else if (wr_acc && in_sel && sel_idx == 4'(gs)) begin // [R21]
                    sel_r[gs].fn  <= ofs_fn_type'(new_w[`OFS_SEL_FN_LSB +: 5]);
                    sel_r[gs].idx <= new_w[`OFS_SEL_IDX_LSB +: 3];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Engine-derived conditions
    // ****************************************************************
    logic clutch_r;
    logic gov_r;
    logic running_r;

    wire logic crank_run  = (ctl.state == ENG_CRANK) || (ctl.state == ENG_WARMUP) ||
                            (ctl.state == ENG_RUN) || (ctl.state == ENG_COOLDOWN);
    wire logic warm_done  = ctl.state == ENG_RUN;
    wire logic in_cool    = ctl.state == ENG_COOLDOWN;
    wire logic standby    = ctl.state == ENG_STANDBY;
    wire logic any_alarm  = ctl.shutdown | ctl.warning |
                            |(adig_act & adig_alarm_en_r);           // [R8] [R15]

    wire logic fuel_lvl   = crank_run;                                 // [R1]
    wire logic ecu_lvl    = ~standby;                                  // [R2]
    wire logic excite_lvl = crank_run;                                 // [R3]
    wire logic pivot_lvl  = crank_run;                                 // [R16]
    wire logic ext_lvl    = any_alarm & ~remind_en_r;                  // [R9]
    wire logic nde_lvl    = ctl.keyed_on & ~ctl.ets_active;            // [R10]
    wire logic ne_lvl     = ctl.ets_active;                            // [R11]
    wire logic fail_lvl   = ctl.attempts_done & ctl.overcrank;         // [R17]
    wire logic ign_off_sb = ctl.keyed_on & ~standby;                   // [R18]
    wire logic ign_on_sb  = ctl.keyed_on;                              // [R19]

    // Clutch is a latch: engage and release thresholds differ, so hold between them
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clutch_r <= 1'b0;
        end else if (warm_done && ctl.rpm >= engage_rpm_r) begin
            clutch_r <= 1'b1;                                          // [R4]
        end else if (in_cool && ctl.rpm <= disengage_rpm_r) begin
            clutch_r <= 1'b0;                                          // [R5]
        end else if (!warm_done && !in_cool) begin
            clutch_r <= 1'b0;
        end
    end

    // Governor follows the state through one register so it drops one clock after cool-down begins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gov_r <= 1'b0;
        end else begin
            gov_r <= (ctl.state == ENG_RUN);                           // [R6]
        end
    end

    // Start detection wins over a stop seen in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            running_r <= 1'b0;
        end else if (ctl.start_det) begin
            running_r <= 1'b1;                                         // [R13]
        end else if (ctl.stop_det) begin
            running_r <= 1'b0;                                         // [R13]
        end
    end

    // ****************************************************************
    // Per-output function selection
    // ****************************************************************
    logic [NO-1:0] out_lvl;
    logic [NO-1:0] out_r;

    genvar go;
    generate
        for (go = 0; go < NO; go++) begin : g_out
            wire ofs_fn_type fn  = sel_r[go].fn;
            wire logic [2:0] idx = sel_r[go].idx;
            wire logic din_hit   = (idx < 3'(`OFS_NUM_DIN)) ? din_s2_r[idx] : 1'b0;
            wire logic adig_hit  = adig_act[idx];
            always_comb begin
                case (fn)
                    FN_FUEL:         out_lvl[go] = fuel_lvl;
                    FN_ECU_EN:       out_lvl[go] = ecu_lvl;
                    FN_EXCITE:       out_lvl[go] = excite_lvl;
                    FN_CLUTCH:       out_lvl[go] = clutch_r;
                    FN_GOV:          out_lvl[go] = gov_r;
                    FN_SHUTDOWN:     out_lvl[go] = ctl.shutdown;      // [R7]
                    FN_COMMON_ALARM: out_lvl[go] = any_alarm;         // [R8]
                    FN_REMOTE_ALARM: out_lvl[go] = any_alarm;         // [R8]
                    FN_DAMPER_NDE:   out_lvl[go] = nde_lvl;
                    FN_NOT_AUTO:     out_lvl[go] = ctl.manual;        // [R12]
                    FN_DAMPER_NE:    out_lvl[go] = ne_lvl;
                    FN_ENG_RUNNING:  out_lvl[go] = running_r;
                    FN_THR_INC:      out_lvl[go] = ctl.thr_inc;       // [R20]
                    FN_THR_DEC:      out_lvl[go] = ctl.thr_dec;       // [R20]
                    FN_DIG_IN:       out_lvl[go] = din_hit;           // [R14]
                    FN_ANA_DIG:      out_lvl[go] = adig_hit;          // [R15]
                    FN_EXT_ALARM:    out_lvl[go] = ext_lvl;
                    FN_PIVOT:        out_lvl[go] = pivot_lvl;
                    FN_FAIL_START:   out_lvl[go] = fail_lvl;
                    FN_IGN_OFF_SB:   out_lvl[go] = ign_off_sb;
                    FN_IGN_ON_SB:    out_lvl[go] = ign_on_sb;
                    // Unused and undefined codes stay off whatever else happens
                    default:         out_lvl[go] = 1'b0;              // [R23]
                endcase
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            out_r <= '0;
        end else begin
            out_r <= out_lvl;
        end
    end

    assign relay_out = out_r[`OFS_NUM_RELAY-1:0];
    assign dig_out   = out_r[NO-1:`OFS_NUM_RELAY];

    // ****************************************************************
    // CAN transmit gate
    // ****************************************************************
    // Gated by the same level that drives any ECU-enable output
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            can_tx_en <= 1'b0;
        end else begin
            can_tx_en <= ecu_lvl;                                      // [R22]
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire logic [31:0] status_word = {12'h000, can_tx_en, running_r, gov_r, clutch_r,
                                     4'h0, out_r};
    wire logic [31:0] inputs_word = {8'h00, adig_alarm_en_r, adig_act, 2'b00, din_s2_r};
    wire ofs_sel_type sel_rd      = sel_r[sel_idx];
    wire logic [31:0] sel_word    = {21'h00_0000, sel_rd.idx, 3'h0, sel_rd.fn};
    wire logic [31:0] rd_mux      = hit_ctrl   ? ctrl_word   :
                                    hit_speed  ? speed_word  :
                                    hit_status ? status_word :
                                    hit_inputs ? inputs_word :
                                    in_sel     ? sel_word    : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_r <= 32'h0000_0000;
        end else if (req && wait_r) begin
            rdata_r <= avs_read ? rd_mux : 32'h0000_0000;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

endmodule
